/* csd_pkg.sv */
// constants, level codes and carrier structs for the strap decoder
package csd_pkg;
    localparam int GPIO_W = 8;
    localparam int PORTS = 6;
    localparam int LVL_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SYNC_DEPTH = 2;
    localparam logic [1:0] CAP_WAIT = 2'h3;
    localparam logic [1:0] CAP_FIRE = 2'h1;

    // level codes delivered by the resistor sensing circuit
    typedef enum logic [2:0] {
        LVL_WEAK_PD = 3'h0,
        LVL_WEAK_PU = 3'h1,
        LVL_MED_PD = 3'h2,
        LVL_MED_PU = 3'h3,
        LVL_STRONG_PD = 3'h4,
        LVL_STRONG_PU = 3'h5
    } csd_lvl_e;

    typedef enum logic [2:0] {
        PRESET_NONE = 3'h0,
        PRESET_BRIDGE = 3'h1,
        PRESET_SLAVE = 3'h2,
        PRESET_RSVD3 = 3'h3,
        PRESET_RSVD4 = 3'h4,
        PRESET_RSVD5 = 3'h5,
        PRESET_RSVD6 = 3'h6
    } csd_preset_e;

    typedef enum logic [1:0] {
        STG_IDLE = 2'h0,
        STG_EXT_CFG = 2'h1,
        STG_FUSE_CFG = 2'h2
    } csd_stage_e;

    localparam logic [7:0] REG_GPIO_DIR = 8'h00;
    localparam logic [7:0] REG_GPIO_OUT = 8'h04;
    localparam logic [7:0] REG_GPIO_PULL_EN = 8'h08;
    localparam logic [7:0] REG_GPIO_PULL_UP = 8'h0c;
    localparam logic [7:0] REG_GPIO_IN = 8'h10;
    localparam logic [7:0] REG_MODE = 8'h14;
    localparam logic [7:0] REG_PORT_OFF = 8'h18;
    localparam logic [7:0] REG_FIXED = 8'h1c;
    localparam logic [7:0] REG_CHARGE = 8'h20;
    localparam logic [7:0] REG_CFG_DONE = 8'h24;

    localparam logic [7:0] GPIO_DIR_RST = 8'h00;
    localparam logic [7:0] GPIO_OUT_RST = 8'h00;
    localparam logic [7:0] GPIO_PULL_EN_RST = 8'h00;
    localparam logic [7:0] GPIO_PULL_UP_RST = 8'h00;
    localparam int MODE_STAGE_LSB = 4;
    localparam int CFG_DONE_BIT = 0;

    typedef struct packed {
        logic [LVL_W-1:0] mode_lvl;
        logic [LVL_W-1:0] fixed_lvl;
        logic [LVL_W-1:0] charge_lvl;
        logic [LVL_W-1:0] smbdat_lvl;
        logic [LVL_W-1:0] smbclk_lvl;
        logic [PORTS-1:0] dplus_port_off_strap;
        logic [PORTS-1:0] dminus_port_off_strap;
    } csd_strap_s;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } csd_wreq_s;

    typedef struct packed {
        logic [GPIO_W-1:0] dir;
        logic [GPIO_W-1:0] out;
        logic [GPIO_W-1:0] pull_en;
        logic [GPIO_W-1:0] pull_up;
    } csd_gpio_s;
endpackage : csd_pkg

/* csd_sync.sv */
// two-flop synchroniser for pin-side levels
`timescale 1ns/1ps
`default_nettype none
module csd_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    if (W < 1)
    begin : g_bad_w
        $error("csd_sync: W must be at least 1");
    end

    // meta_q feeds dout only, so no logic ever sees a metastable level
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : csd_sync
`default_nettype wire

/* csd_top.sv */
// strap capture, preset decode and runtime gpio register file
`timescale 1ns/1ps
`default_nettype none
module csd_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_reset_n_pin,
    input wire csd_pkg::csd_strap_s strap_pins,
    input wire logic [csd_pkg::GPIO_W-1:0] gpio_in_pins,
    input wire logic [csd_pkg::ADDR_W-1:0] smb_addr,
    input wire logic [csd_pkg::DATA_W-1:0] smb_wdata,
    input wire logic smb_wr,
    input wire logic smb_rd,
    output logic [csd_pkg::DATA_W-1:0] smb_rdata,
    input wire logic [csd_pkg::ADDR_W-1:0] brg_addr,
    input wire logic [csd_pkg::DATA_W-1:0] brg_wdata,
    input wire logic brg_wr,
    output csd_pkg::csd_preset_e mode_preset,
    output csd_pkg::csd_stage_e cfg_stage,
    output logic strap_valid,
    output logic [csd_pkg::PORTS-1:0] usb2_port_off,
    output logic [csd_pkg::PORTS-1:0] usb3_port_off,
    output logic [csd_pkg::PORTS-1:0] fixed_port_mask,
    output logic [csd_pkg::PORTS-1:0] charge_port_mask,
    output logic [csd_pkg::GPIO_W-1:0] gpio_out,
    output logic [csd_pkg::GPIO_W-1:0] gpio_oe,
    output logic [csd_pkg::GPIO_W-1:0] gpio_pu_en,
    output logic [csd_pkg::GPIO_W-1:0] gpio_pd_en
);
    typedef struct packed {
        logic [1:0] cap_wait;
        logic chip_rn_prev;
        logic valid;
        csd_pkg::csd_preset_e preset;
        csd_pkg::csd_stage_e stage;
        logic [csd_pkg::PORTS-1:0] u2_off;
        logic [csd_pkg::PORTS-1:0] u3_off;
        logic [csd_pkg::PORTS-1:0] fixed;
        logic [csd_pkg::PORTS-1:0] charge;
        csd_pkg::csd_gpio_s gpio;
        logic [csd_pkg::GPIO_W-1:0] pu_en;
        logic [csd_pkg::GPIO_W-1:0] pd_en;
        logic [csd_pkg::DATA_W-1:0] rdata;
    } csd_state_s;

    csd_state_s s_q;
    csd_state_s s_d;
    csd_pkg::csd_strap_s strap_s;
    logic [csd_pkg::GPIO_W-1:0] gpio_in_s;
    logic chip_rn_s;
    csd_pkg::csd_wreq_s smb_req;
    csd_pkg::csd_wreq_s brg_req;

    // end point and step of the post-reset capture wait counter, and the mode word fields
    localparam logic [1:0] CAP_IDLE = 2'h0;
    localparam logic [1:0] CAP_STEP = 2'h1;
    localparam int PRESET_W = $bits(csd_pkg::csd_preset_e);
    localparam int STAGE_W = $bits(csd_pkg::csd_stage_e);

    // the decode tables are written for six ports and 3-bit level codes
    if (csd_pkg::PORTS != 6)
    begin : g_bad_ports
        $error("csd_top: port masks are written for six ports");
    end
    if (csd_pkg::LVL_W != 3)
    begin : g_bad_lvl
        $error("csd_top: level codes must be 3 bits wide");
    end
    if (csd_pkg::GPIO_W > csd_pkg::DATA_W)
    begin : g_bad_gpio
        $error("csd_top: gpio bank wider than the data word");
    end
    if (csd_pkg::MODE_STAGE_LSB < PRESET_W)
    begin : g_bad_overlap
        $error("csd_top: stage field overlaps the preset field");
    end
    if (csd_pkg::MODE_STAGE_LSB + STAGE_W > csd_pkg::DATA_W)
    begin : g_bad_stage
        $error("csd_top: stage field falls outside the data word");
    end
    if (csd_pkg::CFG_DONE_BIT >= csd_pkg::DATA_W)
    begin : g_bad_done
        $error("csd_top: done bit falls outside the data word");
    end
    // a shorter wait would capture straps before the synchronisers have filled
    if (csd_pkg::CAP_WAIT < csd_pkg::CAP_FIRE + csd_pkg::SYNC_DEPTH)
    begin : g_bad_wait
        $error("csd_top: capture wait shorter than the synchroniser");
    end

    // strap levels, chip reset and gpio inputs come from pins
    csd_sync #(
        .W($bits(csd_pkg::csd_strap_s))
    ) u_strap_sync (
        .mclk(mclk),
        .rst(rst),
        .din(strap_pins),
        .dout(strap_s)
    );

    // the chip reset goes through the same depth so edge and straps line up
    csd_sync #(
        .W(1)
    ) u_rn_sync (
        .mclk(mclk),
        .rst(rst),
        .din(chip_reset_n_pin),
        .dout(chip_rn_s)
    );

    csd_sync #(
        .W(csd_pkg::GPIO_W)
    ) u_gpio_sync (
        .mclk(mclk),
        .rst(rst),
        .din(gpio_in_pins),
        .dout(gpio_in_s)
    );

    assign smb_req = '{wr: smb_wr, addr: smb_addr, data: smb_wdata};
    assign brg_req = '{wr: brg_wr, addr: brg_addr, data: brg_wdata};

    // six options decode to a count of ports starting at port 1
    function automatic logic [csd_pkg::PORTS-1:0] csd_count_mask(
        input logic [csd_pkg::LVL_W-1:0] lvl
    );
        logic [csd_pkg::PORTS-1:0] m;
        m = 6'h00;
        case (csd_pkg::csd_lvl_e'(lvl))
            csd_pkg::LVL_WEAK_PD: m = 6'h00;
            csd_pkg::LVL_WEAK_PU: m = 6'h01;
            csd_pkg::LVL_MED_PD: m = 6'h03;
            csd_pkg::LVL_MED_PU: m = 6'h07;
            csd_pkg::LVL_STRONG_PD: m = 6'h0f;
            csd_pkg::LVL_STRONG_PU: m = 6'h3f;
            // codes 6 and 7 never come from the sensor; treat as weak pull-down
            default: m = 6'h00;
        endcase
        return m;
    endfunction : csd_count_mask

    function automatic csd_pkg::csd_preset_e csd_mode_decode(
        input logic [csd_pkg::LVL_W-1:0] lvl
    );
        csd_pkg::csd_preset_e p;
        p = csd_pkg::PRESET_BRIDGE;
        case (csd_pkg::csd_lvl_e'(lvl))
            csd_pkg::LVL_WEAK_PD: p = csd_pkg::PRESET_BRIDGE;
            csd_pkg::LVL_WEAK_PU: p = csd_pkg::PRESET_SLAVE;
            csd_pkg::LVL_MED_PD: p = csd_pkg::PRESET_RSVD3;
            csd_pkg::LVL_MED_PU: p = csd_pkg::PRESET_RSVD4;
            csd_pkg::LVL_STRONG_PD: p = csd_pkg::PRESET_RSVD5;
            csd_pkg::LVL_STRONG_PU: p = csd_pkg::PRESET_RSVD6;
            default: p = csd_pkg::PRESET_BRIDGE;
        endcase
        return p;
    endfunction : csd_mode_decode

    // one register write into the gpio file, shared by both write paths
    function automatic csd_pkg::csd_gpio_s csd_gpio_write(
        input csd_pkg::csd_gpio_s g,
        input csd_pkg::csd_wreq_s w
    );
        csd_pkg::csd_gpio_s r;
        r = g;
        if (w.wr)
        begin
            if (w.addr == csd_pkg::REG_GPIO_DIR)
                r.dir = w.data[csd_pkg::GPIO_W-1:0];
            else if (w.addr == csd_pkg::REG_GPIO_OUT)
                r.out = w.data[csd_pkg::GPIO_W-1:0];
            else if (w.addr == csd_pkg::REG_GPIO_PULL_EN)
                r.pull_en = w.data[csd_pkg::GPIO_W-1:0];
            else if (w.addr == csd_pkg::REG_GPIO_PULL_UP)
                r.pull_up = w.data[csd_pkg::GPIO_W-1:0];
        end
        return r;
    endfunction : csd_gpio_write

    function automatic logic csd_is_done(input csd_pkg::csd_wreq_s w);
        return w.wr && (w.addr == csd_pkg::REG_CFG_DONE)
            && w.data[csd_pkg::CFG_DONE_BIT];
    endfunction : csd_is_done

    // unmapped offsets read as zero, so software may probe without side effects
    function automatic logic [csd_pkg::DATA_W-1:0] csd_read(
        input csd_state_s st,
        input logic [csd_pkg::ADDR_W-1:0] a,
        input logic [csd_pkg::GPIO_W-1:0] pins
    );
        logic [csd_pkg::DATA_W-1:0] d;
        d = '0;
        if (a == csd_pkg::REG_GPIO_DIR)
            d[csd_pkg::GPIO_W-1:0] = st.gpio.dir;
        else if (a == csd_pkg::REG_GPIO_OUT)
            d[csd_pkg::GPIO_W-1:0] = st.gpio.out;
        else if (a == csd_pkg::REG_GPIO_PULL_EN)
            d[csd_pkg::GPIO_W-1:0] = st.gpio.pull_en;
        else if (a == csd_pkg::REG_GPIO_PULL_UP)
            d[csd_pkg::GPIO_W-1:0] = st.gpio.pull_up;
        else if (a == csd_pkg::REG_GPIO_IN)
            d[csd_pkg::GPIO_W-1:0] = pins;
        else if (a == csd_pkg::REG_MODE)
        begin
            d[PRESET_W-1:0] = st.preset;
            d[csd_pkg::MODE_STAGE_LSB +: STAGE_W] = st.stage;
        end
        else if (a == csd_pkg::REG_PORT_OFF)
            d[csd_pkg::PORTS-1:0] = st.u2_off;
        else if (a == csd_pkg::REG_FIXED)
            d[csd_pkg::PORTS-1:0] = st.fixed;
        else if (a == csd_pkg::REG_CHARGE)
            d[csd_pkg::PORTS-1:0] = st.charge;
        return d;
    endfunction : csd_read

    logic capture;
    logic [csd_pkg::PORTS-1:0] both_high;

    always_comb
    begin
        s_d = s_q;
        s_d.chip_rn_prev = chip_rn_s;
        s_d.rdata = '0;
        // wait for the synchronisers to fill before the post-reset capture
        if (s_q.cap_wait != CAP_IDLE)
            s_d.cap_wait = s_q.cap_wait - CAP_STEP;
        capture = (s_q.cap_wait == csd_pkg::CAP_FIRE) && chip_rn_s;
        if (chip_rn_s && !s_q.chip_rn_prev)
            capture = 1'b1;
        both_high = strap_s.dplus_port_off_strap
            & strap_s.dminus_port_off_strap;

        if (!chip_rn_s)
        begin
            // standby: valid, stage and the gpio file clear while chip reset is held; latched strap results are kept
            s_d.valid = 1'b0;
            s_d.stage = csd_pkg::STG_IDLE;
            s_d.gpio.dir = csd_pkg::GPIO_DIR_RST;
            s_d.gpio.out = csd_pkg::GPIO_OUT_RST;
            s_d.gpio.pull_en = csd_pkg::GPIO_PULL_EN_RST;
            s_d.gpio.pull_up = csd_pkg::GPIO_PULL_UP_RST;
        end
        else
        begin
            if (capture)
            begin
                s_d.valid = 1'b1;
                s_d.preset = csd_mode_decode(strap_s.mode_lvl);
                s_d.u2_off = both_high;
                s_d.u3_off = both_high;
                s_d.fixed = csd_count_mask(strap_s.fixed_lvl);
                s_d.charge = csd_count_mask(strap_s.charge_lvl);
            end
            // bridge applied after smbus: on a same-register collision it wins
            s_d.gpio = csd_gpio_write(s_q.gpio, smb_req);
            s_d.gpio = csd_gpio_write(s_d.gpio, brg_req);
            case (s_q.stage)
                csd_pkg::STG_IDLE:
                begin
                    if (capture)
                    begin
                        if ((csd_mode_decode(strap_s.mode_lvl) == csd_pkg::PRESET_SLAVE)
                            && (strap_s.smbdat_lvl == csd_pkg::LVL_MED_PU)
                            && (strap_s.smbclk_lvl == csd_pkg::LVL_MED_PU))
                            s_d.stage = csd_pkg::STG_EXT_CFG;
                        else
                            s_d.stage = csd_pkg::STG_FUSE_CFG;
                    end
                end
                csd_pkg::STG_EXT_CFG:
                begin
                    // external controller holds this stage until it writes done
                    if (csd_is_done(smb_req) || csd_is_done(brg_req))
                        s_d.stage = csd_pkg::STG_FUSE_CFG;
                end
                csd_pkg::STG_FUSE_CFG:
                begin
                    s_d.stage = csd_pkg::STG_FUSE_CFG;
                end
                default:
                begin
                    s_d.stage = csd_pkg::STG_IDLE;
                end
            endcase
        end

        if (smb_rd)
            s_d.rdata = csd_read(s_q, smb_addr, gpio_in_s);

        // pulls only act on pins in input mode
        s_d.pu_en = ~s_d.gpio.dir & s_d.gpio.pull_en & s_d.gpio.pull_up;
        s_d.pd_en = ~s_d.gpio.dir & s_d.gpio.pull_en & ~s_d.gpio.pull_up;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            // named defaults are spelled out so a changed constant still lands
            s_q <= '0;
            s_q.cap_wait <= csd_pkg::CAP_WAIT;
            s_q.preset <= csd_pkg::PRESET_NONE;
            s_q.stage <= csd_pkg::STG_IDLE;
            s_q.gpio.dir <= csd_pkg::GPIO_DIR_RST;
            s_q.gpio.out <= csd_pkg::GPIO_OUT_RST;
            s_q.gpio.pull_en <= csd_pkg::GPIO_PULL_EN_RST;
            s_q.gpio.pull_up <= csd_pkg::GPIO_PULL_UP_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign smb_rdata = s_q.rdata;
    assign mode_preset = s_q.preset;
    assign cfg_stage = s_q.stage;
    assign strap_valid = s_q.valid;
    assign usb2_port_off = s_q.u2_off;
    assign usb3_port_off = s_q.u3_off;
    assign fixed_port_mask = s_q.fixed;
    assign charge_port_mask = s_q.charge;
    assign gpio_out = s_q.gpio.out;
    assign gpio_oe = s_q.gpio.dir;
    assign gpio_pu_en = s_q.pu_en;
    assign gpio_pd_en = s_q.pd_en;
endmodule : csd_top
`default_nettype wire

/* csd_board.sv */
// board strap resistors, reset source and gpio pin loads
`timescale 1ns/1ps
`default_nettype none
module csd_board (
    input wire logic mclk,
    input wire csd_pkg::csd_strap_s strap_cfg,
    input wire logic reset_hold,
    input wire logic [7:0] ext_high,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] gpio_pu_en,
    input wire logic [7:0] gpio_pd_en,
    output var csd_pkg::csd_strap_s strap_pins,
    output logic chip_reset_n_pin,
    output logic [7:0] gpio_in_pins
);
    // a pin nobody drives or pulls wanders, so it toggles instead of holding a level
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge mclk)
        float_q <= ~float_q;
    // a port is only switched off with both of its straps tied high
    assign strap_pins = strap_cfg;
    assign chip_reset_n_pin = ~reset_hold;
    assign gpio_in_pins = (gpio_oe & gpio_out) | (~gpio_oe & ext_high)
        | (~gpio_oe & ~ext_high & (gpio_pu_en | (~gpio_pd_en & float_q)));
endmodule : csd_board
`default_nettype wire

/* csd_top_asserts.sv */
// port-level assertions for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module csd_top_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_reset_n_pin,
    input wire csd_pkg::csd_strap_s strap_pins,
    input wire logic [7:0] smb_addr,
    input wire logic [31:0] smb_wdata,
    input wire logic smb_wr,
    input wire logic [7:0] brg_addr,
    input wire logic [31:0] brg_wdata,
    input wire logic brg_wr,
    input wire csd_pkg::csd_preset_e mode_preset,
    input wire csd_pkg::csd_stage_e cfg_stage,
    input wire logic strap_valid,
    input wire logic [5:0] usb2_port_off,
    input wire logic [5:0] usb3_port_off,
    input wire logic [5:0] fixed_port_mask,
    input wire logic [5:0] charge_port_mask,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] gpio_pu_en,
    input wire logic [7:0] gpio_pd_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [7:0] smb_lo = smb_wdata[7:0];
    wire logic [7:0] brg_lo = brg_wdata[7:0];
    function automatic logic [2:0] pre_of(input logic [2:0] l);
        return (l < 3'h6) ? l + 3'h1 : 3'h1;
    endfunction : pre_of
    function automatic logic [5:0] mask_of(input logic [2:0] l);
        return (l < 3'h5) ? (6'h01 << l) - 6'h01 : ((l == 3'h5) ? 6'h3f : 6'h00);
    endfunction : mask_of
    sequence s_cap;
        $rose(strap_valid);
    endsequence
    sequence s_rel;
        $rose(chip_reset_n_pin) ##1 chip_reset_n_pin [*4];
    endsequence
    // synced chip reset is surely high once the pin and valid held for four edges
    sequence s_live;
        (chip_reset_n_pin && strap_valid) [*4];
    endsequence
    a_mode_decode: assert property (
        s_cap |-> mode_preset == pre_of(strap_pins.mode_lvl))
        else $error("mode preset wrong at capture");
    a_fixed_decode: assert property (
        s_cap |-> fixed_port_mask == mask_of(strap_pins.fixed_lvl))
        else $error("fixed port mask wrong at capture");
    a_charge_decode: assert property (
        s_cap |-> charge_port_mask == mask_of(strap_pins.charge_lvl))
        else $error("charge port mask wrong at capture");
    a_port_and: assert property (
        s_cap |-> usb2_port_off == (strap_pins.dplus_port_off_strap
            & strap_pins.dminus_port_off_strap))
        else $error("port off not the and of both straps");
    a_super_follow: assert property (
        usb3_port_off == usb2_port_off)
        else $error("superspeed off differs from usb2 off");
    a_stage_pick: assert property (
        s_cap |-> cfg_stage == ((mode_preset == csd_pkg::PRESET_SLAVE
            && strap_pins.smbdat_lvl == 3'h3 && strap_pins.smbclk_lvl == 3'h3)
            ? csd_pkg::STG_EXT_CFG : csd_pkg::STG_FUSE_CFG))
        else $error("wrong stage after capture");
    a_rst_clear: assert property (
        $fell(rst) |-> (!strap_valid && usb2_port_off == 6'h00) [*2])
        else $error("outputs not cleared after reset");
    a_hold_low: assert property (
        !chip_reset_n_pin [*5] |-> !strap_valid && cfg_stage == csd_pkg::STG_IDLE)
        else $error("valid or stage kept in chip reset");
    a_relatch_now: assert property (
        s_rel |-> strap_valid)
        else $error("no capture after chip reset release");
    a_hold_straps: assert property (
        strap_valid && $past(strap_valid) |-> $stable(usb2_port_off) && $stable(mode_preset))
        else $error("latched straps changed between captures");
    a_smb_dir: assert property (
        s_live ##0 (smb_wr && smb_addr == csd_pkg::REG_GPIO_DIR && !brg_wr)
        |=> gpio_oe == $past(smb_lo))
        else $error("smbus direction write not applied");
    a_brg_out: assert property (
        s_live ##0 (brg_wr && brg_addr == csd_pkg::REG_GPIO_OUT) |=> gpio_out == $past(brg_lo))
        else $error("bridge output write not applied");
    a_pull_split: assert property (
        (gpio_pu_en & gpio_pd_en) == 8'h00 && ((gpio_pu_en | gpio_pd_en) & gpio_oe) == 8'h00)
        else $error("pull enabled on output or both pulls on");
endmodule : csd_top_asserts
bind csd_top csd_top_asserts i_csd_top_asserts (.mclk, .rst, .chip_reset_n_pin, .strap_pins,
    .smb_addr, .smb_wdata, .smb_wr, .brg_addr, .brg_wdata, .brg_wr, .mode_preset, .cfg_stage,
    .strap_valid, .usb2_port_off, .usb3_port_off, .fixed_port_mask, .charge_port_mask,
    .gpio_out, .gpio_oe, .gpio_pu_en, .gpio_pd_en);
`default_nettype wire

/* tb_csd_top.sv */
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_csd_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rhold = 1'b0;
    logic [7:0] ext_high = 8'h00;
    csd_pkg::csd_strap_s cfg = '0;
    logic [7:0] smb_addr = 8'h00, brg_addr = 8'h00;
    logic [31:0] smb_wdata = 32'h0, brg_wdata = 32'h0, smb_rdata, d;
    logic smb_wr = 1'b0, smb_rd = 1'b0, brg_wr = 1'b0, strap_valid;
    wire logic chip_reset_n_pin;
    wire csd_pkg::csd_strap_s strap_pins;
    wire logic [7:0] gpio_in_pins;
    csd_pkg::csd_preset_e mode_preset;
    csd_pkg::csd_stage_e cfg_stage;
    logic [5:0] usb2_port_off, usb3_port_off, fixed_port_mask, charge_port_mask;
    logic [7:0] gpio_out, gpio_oe, gpio_pu_en, gpio_pd_en;
    int bad_count = 0;
    int cmp_count = 0;
    logic [5:0] mtab [8] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h3f, 6'h00, 6'h00};
    always #5 mclk = ~mclk;
    csd_top i_csd_top (.mclk, .rst, .chip_reset_n_pin, .strap_pins, .gpio_in_pins, .smb_addr,
        .smb_wdata, .smb_wr, .smb_rd, .smb_rdata, .brg_addr, .brg_wdata, .brg_wr, .mode_preset,
        .cfg_stage, .strap_valid, .usb2_port_off, .usb3_port_off, .fixed_port_mask,
        .charge_port_mask, .gpio_out, .gpio_oe, .gpio_pu_en, .gpio_pd_en);
    csd_board i_csd_board (.mclk, .strap_cfg(cfg), .reset_hold(rhold), .ext_high, .gpio_out,
        .gpio_oe, .gpio_pu_en, .gpio_pd_en, .strap_pins, .chip_reset_n_pin, .gpio_in_pins);
    task automatic wr(input logic brg, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        smb_wr <= !brg;
        brg_wr <= brg;
        smb_addr <= a;
        brg_addr <= a;
        smb_wdata <= v;
        brg_wdata <= v;
        @(posedge mclk);
        smb_wr <= 1'b0;
        brg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        smb_rd <= 1'b1;
        smb_addr <= a;
        @(posedge mclk);
        smb_rd <= 1'b0;
        #1;
        d = smb_rdata;
    endtask : rd
    // straps settle while the chip reset is held, so they are stable well before capture
    task automatic cap(input logic [2:0] m, f, c, sd, sk, input logic [5:0] p, q);
        @(posedge mclk);
        cfg <= {m, f, c, sd, sk, p, q};
        rhold <= 1'b1;
        repeat (5) @(posedge mclk);
        rhold <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(strap_valid, 1'b1)
    endtask : cap
    task automatic t_reset();
        @(posedge mclk);
        #1;
        `CHK(strap_valid, 1'b0)
        repeat (3) @(posedge mclk);
        #1;
        `CHK(strap_valid, 1'b1)
        `CHK(mode_preset, csd_pkg::PRESET_BRIDGE)
        rd(csd_pkg::REG_GPIO_DIR);
        `CHK(d[7:0], csd_pkg::GPIO_DIR_RST)
        rd(csd_pkg::REG_GPIO_PULL_EN);
        `CHK(d[7:0], csd_pkg::GPIO_PULL_EN_RST)
        rd(8'hf0);
        `CHK(d, 32'h0)
    endtask : t_reset
    task automatic t_levels();
        for (int l = 0; l < 8; l++)
        begin
            cap(3'(l), 3'(l), 3'((l + 3) % 8), 3'h3, 3'h3, 6'h00, 6'h00);
            `CHK(mode_preset, (l < 6) ? 3'(l + 1) : 3'h1)
            `CHK(fixed_port_mask, mtab[l])
            `CHK(charge_port_mask, mtab[(l + 3) % 8])
            `CHK(cfg_stage, (l == 1) ? csd_pkg::STG_EXT_CFG : csd_pkg::STG_FUSE_CFG)
            rd(csd_pkg::REG_MODE);
            `CHK(d[2:0], (l < 6) ? 3'(l + 1) : 3'h1)
        end
    endtask : t_levels
    task automatic t_stage();
        cap(3'h1, 3'h0, 3'h0, 3'h3, 3'h2, 6'h00, 6'h00);
        `CHK(cfg_stage, csd_pkg::STG_FUSE_CFG)
        cap(3'h1, 3'h0, 3'h0, 3'h3, 3'h3, 6'h00, 6'h00);
        `CHK(cfg_stage, csd_pkg::STG_EXT_CFG)
        wr(1'b1, csd_pkg::REG_CFG_DONE, 32'h2);
        `CHK(cfg_stage, csd_pkg::STG_EXT_CFG)
        wr(1'b0, csd_pkg::REG_CFG_DONE, 32'h1);
        `CHK(cfg_stage, csd_pkg::STG_FUSE_CFG)
    endtask : t_stage
    task automatic t_ports();
        cap(3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 6'h2b, 6'h19);
        `CHK(usb2_port_off, 6'h09)
        `CHK(usb3_port_off, 6'h09)
        @(posedge mclk);
        cfg <= '1;
        repeat (6) @(posedge mclk);
        rd(csd_pkg::REG_PORT_OFF);
        `CHK(d[5:0], 6'h09)
    endtask : t_ports
    task automatic t_gpio();
        wr(1'b0, csd_pkg::REG_GPIO_DIR, 32'h0f);
        wr(1'b0, csd_pkg::REG_GPIO_OUT, 32'ha5);
        wr(1'b1, csd_pkg::REG_GPIO_PULL_EN, 32'hf0);
        wr(1'b1, csd_pkg::REG_GPIO_PULL_UP, 32'h30);
        wr(1'b0, csd_pkg::REG_MODE, 32'h6);
        ext_high <= 8'h80;
        `CHK({gpio_oe, gpio_out}, 16'h0fa5)
        `CHK({gpio_pu_en, gpio_pd_en}, 16'h30c0)
        `CHK(mode_preset, csd_pkg::PRESET_BRIDGE)
        repeat (4) @(posedge mclk);
        rd(csd_pkg::REG_GPIO_IN);
        `CHK(d[7:0], 8'hb5)
        rhold <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(1'b0, csd_pkg::REG_GPIO_DIR, 32'hff);
        `CHK(gpio_oe, 8'h00)
        rhold <= 1'b0;
        repeat (6) @(posedge mclk);
        wr(1'b1, csd_pkg::REG_GPIO_OUT, 32'h3c);
        `CHK(gpio_out, 8'h3c)
    endtask : t_gpio
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_levels();
        t_stage();
        t_ports();
        t_gpio();
        finish_test();
    end
endmodule : tb_csd_top
`default_nettype wire
